/* rtl/sram_port_pkg.sv */
// Constants shared by the expansion port controller and its bench
package sram_port_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 24;
  localparam int HALF_W = 16;
  localparam int WAIT_W = 5;
  localparam int CNT_W  = 7;

  // ---------------------------------------------------------------
  // I/O addresses of the registers
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_HIGH = 16'hfff2;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_LOW  = 16'hfff3;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_FULL = 16'hfff4;
  localparam logic [ADDR_W-1:0] ADDR_BUS_WAIT    = 16'hfffc;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int HIGH_LSB = 16;
  localparam int HIGH_W   = 8;
  localparam logic [WAIT_W-1:0] WAIT_RESET   = 5'h1f;
  localparam logic [DATA_W-1:0] SWITCH_RESET = 24'h000000;

  // ---------------------------------------------------------------
  // Wait-state thresholds and timing, counted in clock-output phases
  // ---------------------------------------------------------------
  localparam logic [WAIT_W-1:0] WAIT_TWO   = 5'h02;
  localparam logic [WAIT_W-1:0] WAIT_FOUR  = 5'h04;
  localparam logic [WAIT_W-1:0] WAIT_EIGHT = 5'h08;
  localparam logic [CNT_W-1:0]  BASE_PHASES   = 7'h02;
  localparam logic [CNT_W-1:0]  STROBE_PHASE  = 7'h01;
  localparam logic [CNT_W-1:0]  DATA_PHASE    = 7'h02;
  localparam logic [CNT_W-1:0]  WR_DELAY_HALF = 7'h01;
  localparam logic [CNT_W-1:0]  WR_DELAY_FULL = 7'h02;
  localparam logic [CNT_W-1:0]  TRAIL_ONE     = 7'h02;
  localparam logic [CNT_W-1:0]  TRAIL_TWO     = 7'h04;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_TRAIL
  } bus_state_e;

endpackage

/* rtl/sram_expansion_port.sv */
// Expansion port controller: SRAM bus sequencer, wait control and program word switch
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Every external access inserts the programmed five-bit wait count, zero to thirty-one.
// - Reset loads the wait count with all ones, the maximum.
// - Wait 4..7 adds one trailing state, 8 or more adds two, access time unchanged.
// - Write strobe delay: none at one wait, half clock at 2..3, full clock at 4+.
// - Write: address and select in low phase, strobe next rise, data in a low phase; at zero wait the data is never driven.
// - Read: address and select in low phase, strobe next rise, sample last high phase.
// - Each wait state keeps the address driven longer.
// - Chip select follows the address phase, not the strobes.
// - 24-bit data bus, 16-bit address bus, at most one access per two clocks.
// - Bus wait register is 16 bits; bits 5 to 15 read as zero.
// - Expansion disable bit shuts the port down to save power.
// - Switch register is 24-bit I/O read/write, taking 24-bit or 16-bit access.
// - A 16-bit source into 24 bits takes its top byte from the switch high byte.
// - A 24-bit source into 16 bits keeps only the low 16 bits.
// - Switch appears as full 24-bit, low 16-bit and high 8-bit registers.
// - Full switch address moves all 24 bits in one operation; the code does so only for a 24-bit access, a 16-bit access moves the low 16.
// - Low and high switch accesses are ordinary 16-bit I/O accesses.
// - Reading switch high zeroes the destination bits above its byte.

module sram_expansion_port
  import sram_port_pkg::*;
(
  input  wire logic                          mclk_in,                // Core clock
  input  wire logic                          resetn_in,              // Synchronous reset, low
  input  wire logic                          expansion_disable_bit_in, // Mode bit, port off
  // Core I/O register port
  input  wire logic [sram_port_pkg::ADDR_W-1:0] io_addr_in,          // I/O address
  input  wire logic                          io_rd_in,               // Read strobe
  input  wire logic                          io_wr_in,               // Write strobe
  input  wire logic                          io_wide_in,             // 24-bit access
  input  wire logic [sram_port_pkg::DATA_W-1:0] io_wdata_in,         // Write data
  output logic      [sram_port_pkg::DATA_W-1:0] io_rdata_out,        // Read data
  // Core external access request
  input  wire logic                          ext_req_in,             // Access request level
  input  wire logic                          ext_write_in,           // 1 write, 0 read
  input  wire logic [sram_port_pkg::ADDR_W-1:0] ext_addr_in,         // Access address
  input  wire logic [sram_port_pkg::DATA_W-1:0] ext_wdata_in,        // Access write data
  output logic                               ext_done_out,           // Access finished pulse
  output logic      [sram_port_pkg::DATA_W-1:0] ext_rdata_out,       // Sampled read data
  // External pins
  output logic                               clock_output_pin_out,   // Core clock divided by two
  output logic      [sram_port_pkg::ADDR_W-1:0] external_address_bus_out, // Address
  output logic                               memory_chip_select_n_out, // Chip select, low
  output logic                               read_strobe_n_out,      // Read strobe, low
  output logic                               write_strobe_n_out,     // Write strobe, low
  output logic      [sram_port_pkg::DATA_W-1:0] data_bus_out,        // Data drive value
  output logic                               data_bus_oe_out,        // Data drive enable
  input  wire logic [sram_port_pkg::DATA_W-1:0] data_bus_in          // Data pin level
);
  import sram_port_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [WAIT_W-1:0] wait_count_field;
  logic [DATA_W-1:0] program_word_switch;
  bus_state_e        state;
  logic [CNT_W-1:0]  phase_cnt;
  logic [WAIT_W-1:0] cur_wait;
  logic              cur_write;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] cur_wdata;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire logic hit_full = (io_addr_in == ADDR_SWITCH_FULL);
  wire logic hit_low  = (io_addr_in == ADDR_SWITCH_LOW);
  wire logic hit_high = (io_addr_in == ADDR_SWITCH_HIGH);
  wire logic hit_wait = (io_addr_in == ADDR_BUS_WAIT);

  wire logic [HIGH_W-1:0] switch_high = program_word_switch[DATA_W-1:HIGH_LSB];
  wire logic [HALF_W-1:0] switch_low  = program_word_switch[HALF_W-1:0];

  // 16-bit sources gain the switch high byte when they land in 24 bits
  wire logic [DATA_W-1:0] full_rd = io_wide_in ? program_word_switch
                                              : {8'h00, switch_low};
  wire logic [DATA_W-1:0] low_rd  = io_wide_in ? {switch_high, switch_low}
                                              : {8'h00, switch_low};
  wire logic [DATA_W-1:0] high_rd = {16'h0000, switch_high};
  wire logic [DATA_W-1:0] wait_rd = {19'h00000, wait_count_field};

  wire logic [DATA_W-1:0] next_rdata =
      hit_full ? full_rd :
      hit_low  ? low_rd  :
      hit_high ? high_rd :
      hit_wait ? wait_rd : 24'h000000;

  // A 16-bit write into the full address keeps the stored top byte
  wire logic [DATA_W-1:0] full_wr = io_wide_in ? io_wdata_in
                                              : {switch_high, io_wdata_in[HALF_W-1:0]};

  wire logic [DATA_W-1:0] next_switch =
      (io_wr_in && hit_full) ? full_wr :
      (io_wr_in && hit_low)  ? {switch_high, io_wdata_in[HALF_W-1:0]} :
      (io_wr_in && hit_high) ? {io_wdata_in[HIGH_W-1:0], switch_low} :
      program_word_switch;

  // ---------------------------------------------------------------
  // Access timing derived from the latched wait count
  // ---------------------------------------------------------------
  // Active phases: address and strobe phases plus one clock per wait state
  wire logic [CNT_W-1:0] wait_phases  = {1'b0, cur_wait, 1'b0};
  wire logic [CNT_W-1:0] active_len   = BASE_PHASES + wait_phases;
  wire logic [CNT_W-1:0] trail_len    =
      (cur_wait >= WAIT_EIGHT) ? TRAIL_TWO :
      (cur_wait >= WAIT_FOUR)  ? TRAIL_ONE : 7'h00;
  wire logic [CNT_W-1:0] wr_delay     =
      (cur_wait >= WAIT_FOUR) ? WR_DELAY_FULL :
      (cur_wait >= WAIT_TWO)  ? WR_DELAY_HALF : 7'h00;
  wire logic [CNT_W-1:0] wr_phase     = STROBE_PHASE + wr_delay;
  wire logic [CNT_W-1:0] last_active  = active_len - 7'h01;
  wire logic [CNT_W-1:0] last_trail   = trail_len - 7'h01;

  // Starting only while the clock output is high puts the address in a low phase
  wire logic port_on   = !expansion_disable_bit_in;
  wire logic start     = (state == ST_IDLE) && ext_req_in && port_on
                         && clock_output_pin_out && !ext_done_out;
  wire logic end_act   = (state == ST_ACTIVE) && (phase_cnt == last_active);
  wire logic end_trail = (state == ST_TRAIL) && (phase_cnt == last_trail);
  wire logic finish    = (end_act && (trail_len == 7'h00)) || end_trail;

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  bus_state_e       next_state;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt   = phase_cnt + 7'h01;
    unique case (state)
      ST_IDLE: begin
        next_cnt = 7'h00;
        if (start) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (end_act) begin
          next_cnt   = 7'h00;
          next_state = (trail_len == 7'h00) ? ST_IDLE : ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (end_trail) begin
          next_cnt   = 7'h00;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Pin values for the coming phase, registered below
  wire logic next_active = (next_state == ST_ACTIVE);
  wire logic next_busy   = (next_state != ST_IDLE);
  wire logic next_write  = start ? ext_write_in : cur_write;
  wire logic [WAIT_W-1:0] next_wait = start ? wait_count_field : cur_wait;
  wire logic next_cs_n   = !next_active;
  wire logic next_rd_n   = !(next_active && !next_write
                             && (next_cnt >= STROBE_PHASE));
  wire logic next_wr_n   = !(next_active && next_write
                             && (next_cnt >= wr_phase));
  // Write data stays on the bus through the trailing states for hold time
  wire logic next_oe     = next_busy && next_write
                           && ((next_state == ST_TRAIL) || (next_cnt >= DATA_PHASE));
  // Last active phase is a high phase of the clock output
  wire logic sample_rd   = end_act && !cur_write;

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wait_count_field    <= WAIT_RESET;
      program_word_switch <= SWITCH_RESET;
      io_rdata_out        <= 24'h000000;
    end else begin
      if (io_wr_in && hit_wait) begin
        wait_count_field <= io_wdata_in[WAIT_W-1:0];
      end
      program_word_switch <= next_switch;
      io_rdata_out        <= io_rd_in ? next_rdata : 24'h000000;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state     <= ST_IDLE;
      phase_cnt <= 7'h00;
      cur_wait  <= WAIT_RESET;
      cur_write <= 1'b0;
      cur_addr  <= 16'h0000;
      cur_wdata <= 24'h000000;
    end else begin
      state     <= next_state;
      phase_cnt <= next_cnt;
      cur_wait  <= next_wait;
      cur_write <= next_write;
      if (start) begin
        cur_addr  <= ext_addr_in;
        cur_wdata <= ext_wdata_in;
      end
    end
  end

  // Clock output is held high while the port is disabled to cut switching power
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      clock_output_pin_out <= 1'b1;
    end else begin
      clock_output_pin_out <= port_on ? !clock_output_pin_out : 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      external_address_bus_out <= 16'h0000;
      memory_chip_select_n_out <= 1'b1;
      read_strobe_n_out        <= 1'b1;
      write_strobe_n_out       <= 1'b1;
      data_bus_out             <= 24'h000000;
      data_bus_oe_out          <= 1'b0;
      ext_done_out             <= 1'b0;
      ext_rdata_out            <= 24'h000000;
    end else begin
      if (start) begin
        external_address_bus_out <= ext_addr_in;
        data_bus_out             <= ext_wdata_in;
      end
      memory_chip_select_n_out <= next_cs_n;
      read_strobe_n_out        <= next_rd_n;
      write_strobe_n_out       <= next_wr_n;
      data_bus_oe_out          <= next_oe;
      ext_done_out             <= finish;
      if (sample_rd) begin
        ext_rdata_out <= data_bus_in;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/sram_port_sva.sv */
// Assertion checker for the expansion port controller pins and registers
`timescale 1ns/10ps
`default_nettype none
module sram_port_sva
  import sram_port_pkg::*;
(
  input wire logic                               mclk_in, resetn_in,       // Clock, reset
  input wire logic                               expansion_disable_bit_in, // Port off
  input wire logic                               io_rd_in, io_wr_in,       // Register strobes
  input wire logic [sram_port_pkg::ADDR_W-1:0]   io_addr_in, ext_addr_in,  // Addresses
  input wire logic [sram_port_pkg::DATA_W-1:0]   io_wdata_in, io_rdata_out, // Register data
  input wire logic                               ext_write_in, ext_done_out, // Access control
  input wire logic [sram_port_pkg::DATA_W-1:0]   ext_wdata_in, ext_rdata_out, // Access data
  input wire logic                               clock_output_pin_out,     // Clock pin
  input wire logic [sram_port_pkg::ADDR_W-1:0]   external_address_bus_out, // Address pins
  input wire logic                               memory_chip_select_n_out, // Select pin
  input wire logic                               read_strobe_n_out, write_strobe_n_out, // Strobes
  input wire logic [sram_port_pkg::DATA_W-1:0]   data_bus_out, data_bus_in, // Data pins
  input wire logic                               data_bus_oe_out           // Data enable
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic [4:0] wsh;
  logic [4:0] wl;
  logic [6:0] ccnt;
  logic [6:0] tcnt;
  logic       busy;
  logic       rdy;
  wire  [6:0] trail = (wl >= 5'h08) ? 7'h04 : (wl >= 5'h04) ? 7'h02 : 7'h00;
  wire  [6:0] wrd   = (wl == 5'h01) ? 7'h01 : (wl < 5'h04) ? 7'h02 : 7'h03;
  // The count in use is frozen from the start of an access to its done pulse
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wsh  <= WAIT_RESET;
      wl   <= WAIT_RESET;
      ccnt <= 7'h00;
      tcnt <= 7'h00;
      busy <= 1'b0;
      rdy  <= 1'b0;
    end else begin
      if (io_wr_in && io_addr_in == ADDR_BUS_WAIT) wsh <= io_wdata_in[4:0];
      if (memory_chip_select_n_out && !busy) wl <= wsh;
      ccnt <= memory_chip_select_n_out ? 7'h00 : ccnt + 7'h01;
      tcnt <= memory_chip_select_n_out ? tcnt + 7'h01 : 7'h00;
      busy <= !memory_chip_select_n_out || (busy && !ext_done_out);
      rdy  <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  cs_len_a : assert property (
    rdy && $rose(memory_chip_select_n_out) |-> ccnt == 7'h02 + {1'b0, wl, 1'b0})
    else $error("chip select low time wrong");
  trail_len_a : assert property (ext_done_out |-> tcnt == trail)
    else $error("trailing states wrong");
  wr_delay_a : assert property (
    rdy && $fell(write_strobe_n_out) && wl != 5'h00 |-> ccnt == wrd)
    else $error("write strobe delay wrong");
  rd_strobe_a : assert property (
    rdy && $fell(read_strobe_n_out) |-> clock_output_pin_out && ccnt == 7'h01)
    else $error("read strobe start wrong");
  cs_start_a : assert property (
    rdy && $fell(memory_chip_select_n_out) |-> !clock_output_pin_out && read_strobe_n_out
      && write_strobe_n_out && external_address_bus_out == ext_addr_in)
    else $error("access start wrong");
  strobe_cs_a : assert property (
    !read_strobe_n_out || !write_strobe_n_out |-> !memory_chip_select_n_out)
    else $error("strobe outside select");
  addr_hold_a : assert property (
    !memory_chip_select_n_out && $past(!memory_chip_select_n_out)
      |-> $stable(external_address_bus_out)) else $error("address moved in access");
  data_drive_a : assert property (
    rdy && $rose(data_bus_oe_out) |-> ext_write_in && !clock_output_pin_out
      && data_bus_out == ext_wdata_in) else $error("write data drive wrong");
  read_sample_a : assert property (
    rdy && $rose(memory_chip_select_n_out) && !ext_write_in
      |-> ext_rdata_out == $past(data_bus_in)) else $error("read sample wrong");
  port_off_a : assert property (
    expansion_disable_bit_in && memory_chip_select_n_out
      |=> memory_chip_select_n_out && clock_output_pin_out) else $error("port not off");
  wait_resv_a : assert property (
    $past(io_rd_in) && $past(io_addr_in) == ADDR_BUS_WAIT |-> io_rdata_out[23:5] == 19'h0)
    else $error("reserved bits not zero");
  high_zero_a : assert property (
    $past(io_rd_in) && $past(io_addr_in) == ADDR_SWITCH_HIGH |-> io_rdata_out[23:8] == 16'h0)
    else $error("high part upper bits not zero");
  cover property (ext_done_out && tcnt == 7'h04);
  cover property (rdy && $rose(data_bus_oe_out));
  cover property (expansion_disable_bit_in && clock_output_pin_out);
endmodule
bind sram_expansion_port sram_port_sva chk_u (.mclk_in, .resetn_in,
  .expansion_disable_bit_in, .io_rd_in, .io_wr_in, .io_addr_in, .ext_addr_in, .io_wdata_in,
  .io_rdata_out, .ext_write_in, .ext_done_out, .ext_wdata_in, .ext_rdata_out,
  .clock_output_pin_out, .external_address_bus_out, .memory_chip_select_n_out,
  .read_strobe_n_out, .write_strobe_n_out, .data_bus_out, .data_bus_in, .data_bus_oe_out);
`default_nettype wire

/* tb/sram_model.sv */
// Behavioural static RAM on the far side of the expansion port
`timescale 1ns/10ps
`default_nettype none
module sram_model #(
  parameter int ACC = 1 // Strobe cycles before read data is valid
) (
  input  wire logic        clk_in,    // Core clock
  input  wire logic        cs_n_in,   // Chip select, low
  input  wire logic        rd_n_in,   // Read strobe, low
  input  wire logic        wr_n_in,   // Write strobe, low
  input  wire logic        oe_in,     // Port drives the data bus
  input  wire logic [15:0] addr_in,   // Address
  input  wire logic [23:0] wdata_in,  // Port data
  output logic      [23:0] level_out  // Resolved data pin level
);
  logic [23:0] mem [256];
  logic [23:0] last = 24'h000000;
  int          rcnt = 0;
  wire         rd_on = !rd_n_in && !cs_n_in;
  always @(posedge clk_in) begin
    if (!wr_n_in && !cs_n_in && oe_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
    rcnt <= rd_on ? rcnt + 1 : 0;
    last <= level_out;
  end
  // A released bus shows the inverse of its last level, so a late sample is caught
  assign level_out = oe_in ? wdata_in : (rd_on && rcnt >= ACC) ? mem[addr_in[7:0]] : ~last;
endmodule
`default_nettype wire

/* tb/sram_expansion_port_test.sv */
// Self-checking bench for the expansion port controller
`timescale 1ns/10ps
`default_nettype none
module sram_expansion_port_test;
  import sram_port_pkg::*;
  logic              mclk_in = 1'b0, resetn_in = 1'b0, dis = 1'b0, req = 1'b0, ext_wr = 1'b0;
  logic              io_rd = 1'b0, io_wr = 1'b0, io_wide = 1'b0;
  logic [ADDR_W-1:0] io_addr = '0, ext_addr = '0, addr_bus;
  logic [DATA_W-1:0] io_wdata = '0, ext_wdata = '0, io_rdata, ext_rdata, dbo, dbi;
  logic              done, clko, cs_n, rd_n, wr_n, oe;
  logic [4:0]        wl [7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h08, 5'h1f};
  int                num_errors = 0;
  int                compares = 0;
  always #2 mclk_in = ~mclk_in;
  sram_expansion_port dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .expansion_disable_bit_in(dis), .io_addr_in(io_addr), .io_rd_in(io_rd), .io_wr_in(io_wr),
    .io_wide_in(io_wide), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata), .ext_req_in(req),
    .ext_write_in(ext_wr), .ext_addr_in(ext_addr), .ext_wdata_in(ext_wdata),
    .ext_done_out(done), .ext_rdata_out(ext_rdata), .clock_output_pin_out(clko),
    .external_address_bus_out(addr_bus), .memory_chip_select_n_out(cs_n),
    .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n), .data_bus_out(dbo),
    .data_bus_oe_out(oe), .data_bus_in(dbi));
  sram_model #(.ACC(2)) mem_u (.clk_in(mclk_in), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .oe_in(oe), .addr_in(addr_bus), .wdata_in(dbo), .level_out(dbi));
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic io_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
    @(posedge mclk_in);
    io_addr <= a;
    io_wdata <= d;
    io_wide <= w;
    io_wr <= 1'b1;
    @(posedge mclk_in);
    io_wr <= 1'b0;
  endtask
  task automatic io_read(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] e);
    @(posedge mclk_in);
    io_addr <= a;
    io_wide <= w;
    io_rd <= 1'b1;
    @(posedge mclk_in);
    io_rd <= 1'b0;
    #1 chk("register read", e, io_rdata);
  endtask
  // Counts select-low and trailing cycles; d is the write value or the expected read value
  task automatic ext(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [4:0] wc);
    int nl = 0;
    int nt = 0;
    @(posedge mclk_in);
    req <= 1'b1;
    ext_wr <= w;
    ext_addr <= a;
    ext_wdata <= d;
    for (int i = 0; i < 200 && done !== 1'b1; i++) begin
      @(posedge mclk_in);
      #1;
      if (cs_n === 1'b0) nl++;
      else if (nl > 0 && done !== 1'b1) nt++;
    end
    chk("active cycles", DATA_W'(2 + 2 * wc), DATA_W'(nl));
    chk("trailing cycles", (wc > 5'h07) ? 24'h4 : (wc > 5'h03) ? 24'h2 : 24'h0, DATA_W'(nt));
    if (!w) chk("read data", d, ext_rdata);
    @(posedge mclk_in);
    req <= 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    io_read(ADDR_BUS_WAIT, 1'b0, 24'h00001f);
    ext(1'b1, 16'h0020, 24'h5a0f33, 5'h1f);
    io_write(ADDR_BUS_WAIT, 24'hffffe3, 1'b0);
    io_read(ADDR_BUS_WAIT, 1'b0, 24'h000003);
    io_write(16'hfff0, 24'h00abcd, 1'b0);
    io_read(16'hfff0, 1'b0, 24'h000000);
    $display("register test done");
    foreach (wl[i]) begin
      io_write(ADDR_BUS_WAIT, {19'h0, wl[i]}, 1'b0);
      ext(1'b1, 16'h0010 + 16'(i), 24'ha5c300 + 24'(i), wl[i]);
      ext(1'b0, 16'h0010 + 16'(i), 24'ha5c300 + 24'(i), wl[i]);
    end
    $display("wait state test done");
    io_write(ADDR_BUS_WAIT, 24'h000002, 1'b0);
    fork
      ext(1'b0, 16'h0016, 24'ha5c306, 5'h02);
      begin
        repeat (4) @(posedge mclk_in);
        io_write(ADDR_BUS_WAIT, 24'h000009, 1'b0);
      end
    join
    ext(1'b0, 16'h0016, 24'ha5c306, 5'h09);
    $display("wait update test done");
    io_write(ADDR_SWITCH_FULL, 24'h123456, 1'b1);
    io_read(ADDR_SWITCH_FULL, 1'b1, 24'h123456);
    io_read(ADDR_SWITCH_FULL, 1'b0, 24'h003456);
    io_read(ADDR_SWITCH_LOW, 1'b1, 24'h123456);
    io_read(ADDR_SWITCH_LOW, 1'b0, 24'h003456);
    io_read(ADDR_SWITCH_HIGH, 1'b1, 24'h000012);
    io_read(ADDR_SWITCH_HIGH, 1'b0, 24'h000012);
    io_write(ADDR_SWITCH_LOW, 24'hffabcd, 1'b0);
    io_write(ADDR_SWITCH_HIGH, 24'hff0077, 1'b0);
    io_read(ADDR_SWITCH_FULL, 1'b1, 24'h77abcd);
    io_write(ADDR_SWITCH_FULL, 24'h005555, 1'b0);
    io_read(ADDR_SWITCH_FULL, 1'b1, 24'h775555);
    $display("switch register test done");
    @(posedge mclk_in);
    dis <= 1'b1;
    repeat (20) begin
      @(posedge mclk_in);
      #1 chk("parked pins", 24'h000003, {22'h0, clko, cs_n});
    end
    @(posedge mclk_in);
    dis <= 1'b0;
    ext(1'b0, 16'h0010, 24'ha5c300, 5'h09);
    $display("disable test done");
    stop_test();
  end
endmodule
`default_nettype wire
